//--- abt_port.sv
/*
   abt_port: binary block transfer port of a logic analyzer. Moves bytes
   between the instrument bus and the expected data, word mask and error
   map memories, keeps transfer address, status levels and segment count.
   assumes: command decoder, bus address functions and compare logic run
   on CLK_SYS; bus lines come from transceivers, asynchronous, active low.
*/
`default_nettype none
// Overview of operation
// R1: first byte goes to or comes from the programmed start address
// R2: connector pair names first and last connector forming the byte lanes
// R3: listen_expected writes incoming binary bytes into expected data memory
// R4: talk_expected sends expected data memory as binary bytes
// R5: changing type alone keeps connector pair and start address
// R6: controller marks final byte with EOI; device ends transfer there
// R7: controller stops reading at EOI; CR and LF are plain data
// R8: two status levels; two serial polls clear pending status
// R9: extended variant adds word mask write, word mask read, error map read; type_ok accepts word mask write without EXTENDED
// R10: vector types pack 8 vectors per byte, others 8 channels
// R11: vector transfers start at start address rounded down to multiple of 8
// R12: controller should use start addresses divisible by 8 for vector types
// R13: logical address depends on analysis mode and glitch detection
// R14: expected memory logical address equals physical address
// R15: received map, stop mode: physical zero is most negative logical address
// R16: glitch detection on splits received memory into data and glitch halves
// R17: clear_segments_new leaves one segment; add_segment appends one
// R18: address advances after the byte that completes a memory word
// R19: controller gives even first connector and odd last connector
// R20: bad connector pair forces a service request
// R21: running address returns to start on end, poll, EOI, setting change
// R22: memory is cyclic, writing past the end wraps to the bottom; end of memory here restarts at the start address instead
module abt_port #(
   parameter int AW = abt_pkg::ADDR_W,
   parameter int FD = abt_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // command strobes from the decoder
   input wire logic SEL_STB,
   input wire logic [2:0] SEL_FIRST,
   input wire logic [2:0] SEL_LAST,
   input wire logic ADDR_STB,
   input wire logic [AW-1:0] ADDR_VAL,
   input wire logic TYPE_STB,
   input wire logic [2:0] TYPE_VAL,
   input wire logic CLR_SEG_STB,
   input wire logic ADD_SEG_STB,
   // configuration levels
   input wire logic EXTENDED,
   input wire logic STOP_ANALYSIS,
   input wire logic GLITCH_ON,
   input wire logic [2:0] TOP_CONN,
   // bus address functions
   input wire logic LISTEN_BIN,
   input wire logic TALK_BIN,
   input wire logic ADDR_CHG,
   input wire logic SPOLL_DONE,
   // bus lines, active low, open drain
   input wire logic [7:0] DIO_N_IN,
   output logic [7:0] DIO_N_OUT,
   output logic DIO_N_OE,
   input wire logic DAV_N_IN,
   output logic DAV_N_OUT,
   output logic DAV_N_OE,
   input wire logic NRFD_N_IN,
   output logic NRFD_N_OUT,
   output logic NRFD_N_OE,
   input wire logic NDAC_N_IN,
   output logic NDAC_N_OUT,
   output logic NDAC_N_OE,
   input wire logic EOI_N_IN,
   output logic EOI_N_OUT,
   output logic EOI_N_OE,
   // error map write from compare logic
   input wire logic ERR_WE,
   input wire logic [AW-1:0] ERR_ADDR,
   input wire logic ERR_BIT,
   // status and observation
   output logic SRQ,
   output logic [7:0] STATUS,
   output logic [AW-1:0] XFER_ADDR,
   output logic [AW-1:0] LOG_ADDR,
   output logic LOG_NEG,
   output logic GLITCH_HALF,
   output logic [3:0] SEG_COUNT,
   output logic BUSY
);
   localparam int BW = abt_pkg::BYTE_W;
   localparam int SYW = abt_pkg::SY_W;
   localparam int LW = abt_pkg::LANE_W;
   localparam logic [AW-1:0] ADDR_TOP = '1;
   localparam logic [AW-1:0] VEC_LOW = AW'((1 << abt_pkg::VEC_SH) - 1);
   localparam logic [AW-1:0] VEC_STEP = AW'(1 << abt_pkg::VEC_SH);
   localparam logic [AW-1:0] HALF_TOP = ADDR_TOP >> 1;

   // transfer type decoding
   function automatic logic is_vec(input logic [2:0] t);
      is_vec = (t == abt_pkg::TYPE_LSN_WMASK) | (t == abt_pkg::TYPE_TLK_WMASK) |
               (t == abt_pkg::TYPE_TLK_ERRMAP);
   endfunction

   function automatic logic is_talk(input logic [2:0] t);
      is_talk = (t == abt_pkg::TYPE_TLK_EXP) | (t == abt_pkg::TYPE_TLK_WMASK) |
                (t == abt_pkg::TYPE_TLK_ERRMAP);
   endfunction

   function automatic logic is_listen(input logic [2:0] t);
      is_listen = (t == abt_pkg::TYPE_LSN_EXP) | (t == abt_pkg::TYPE_LSN_WMASK);
   endfunction

   // physical to logical address: {glitch half, negative, magnitude}
   function automatic logic [AW+1:0] map_logical(input logic [AW-1:0] p,
                                                 input logic rcv, input logic stop,
                                                 input logic glitch);
      logic hi;
      logic [AW-1:0] lo;
      hi = glitch & rcv & p[AW-1];
      lo = (glitch & rcv) ? (p & HALF_TOP) : p;
      if (rcv & stop) begin
         map_logical = {hi, 1'b1, (glitch ? HALF_TOP : ADDR_TOP) - lo};
      end else begin
         map_logical = {hi, 1'b0, lo};
      end
   endfunction

   // memories behind the port
   logic [abt_pkg::CHAN_W-1:0] exp_mem [2**AW];
   logic wmask_mem [2**AW];
   logic err_mem [2**AW];

   // settings and running state
   logic [2:0] first_conn;
   logic [2:0] last_conn;
   logic [AW-1:0] start_addr;
   logic [2:0] xtype;
   logic [AW-1:0] addr;
   logic [LW-1:0] lane;
   logic hold;
   logic [abt_pkg::STAT_W-1:0] stat0;
   logic [abt_pkg::STAT_W-1:0] stat1;
   logic [abt_pkg::SEG_W-1:0] segs;
   abt_pkg::abt_link_t st;
   abt_pkg::abt_link_t next_st;
   logic [SYW-1:0] sy1;
   logic [SYW-1:0] sy2;
   logic [SYW-1:0] sy3;
   logic [SYW-1:0] pin;
   logic [BW-1:0] vec_byte;
   logic [AW+1:0] log_map;

   // fifo wires
   logic f_in_valid;
   logic f_in_ready;
   logic [abt_pkg::FIFO_W-1:0] f_in_data;
   logic f_out_valid;
   logic f_out_ready;
   logic [abt_pkg::FIFO_W-1:0] f_out_data;

   // pins arrive in asserted sense; a level counts once stages 2 and 3 agree
   wire [SYW-1:0] raw = ~{EOI_N_IN, NDAC_N_IN, NRFD_N_IN, DAV_N_IN, DIO_N_IN};
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sy1 <= '0;
         sy2 <= '0;
         sy3 <= '0;
         pin <= '0;
      end else begin
         sy1 <= raw;
         sy2 <= sy1;
         sy3 <= sy2;
         pin <= (sy2 & sy3) | (pin & (sy2 | sy3));
      end
   end
   wire dav = pin[abt_pkg::SY_DAV];
   wire nrfd = pin[abt_pkg::SY_NRFD];
   wire ndac = pin[abt_pkg::SY_NDAC];
   wire eoi_in = pin[abt_pkg::SY_EOI];

   // command checks
   wire sel_bad = (SEL_FIRST > SEL_LAST) | (SEL_LAST > TOP_CONN) |
                  SEL_FIRST[0] | ~SEL_LAST[0];                      // see R20
   wire sel_ok = SEL_STB & ~sel_bad;
   wire type_ok = is_listen(TYPE_VAL) | (TYPE_VAL == abt_pkg::TYPE_TLK_EXP) |
                  (TYPE_VAL != abt_pkg::TYPE_LSN_EXP & is_vec(TYPE_VAL) & EXTENDED); // see R9

   // lane and address geometry
   wire vec = is_vec(xtype);
   wire listen_mode = is_listen(xtype);
   wire talk_mode = is_talk(xtype);
   wire lsn_on = LISTEN_BIN & listen_mode;
   wire tlk_on = TALK_BIN & talk_mode;
   wire [LW-1:0] last_lane = LW'((last_conn - first_conn) >> 1);         // see R2
   wire [2:0] conn = first_conn + {lane, 1'b0};
   wire [abt_pkg::CBASE_W-1:0] chan_base = {conn, 2'b00};
   wire word_done = vec | (lane == last_lane);                           // see R10
   wire at_top = (addr | (vec ? VEC_LOW : '0)) == ADDR_TOP;
   wire [AW-1:0] start_eff = vec ? (start_addr & ~VEC_LOW) : start_addr; // see R11

   // byte movers on the memory side of the fifo
   wire wr_pop = listen_mode & f_out_valid & ~hold;
   wire wr_eoi = wr_pop & f_out_data[BW];                                // see R6
   wire rd_req = tlk_on & ~hold;
   wire rd_push = rd_req & f_in_ready;
   wire step = wr_pop | rd_push;
   wire end_mem = step & word_done & at_top;
   wire cfg_change = sel_ok | ADDR_STB | TYPE_STB;
   wire restart = cfg_change | ADDR_CHG | SPOLL_DONE | wr_eoi | end_mem; // see R21

   // fifo steering: the bus fills it when listening, the reader when talking
   wire acc_take = (st == abt_pkg::LK_ACC_WAIT) & dav & ~NRFD_N_OE & f_in_ready;
   wire src_pop = (st == abt_pkg::LK_SRC_DAV) & ~ndac & tlk_on;
   wire [BW-1:0] rd_byte = vec ? vec_byte : exp_mem[addr][chan_base +: BW]; // see R4
   assign f_in_valid = rd_req | acc_take;
   assign f_in_data = talk_mode ? {word_done & at_top, rd_byte} : {eoi_in, pin[BW-1:0]};
   assign f_out_ready = listen_mode ? ~hold : src_pop;

   abt_fifo #(
      .WIDTH(abt_pkg::FIFO_W),
      .DEPTH(FD)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .flush(hold & talk_mode),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   // vector-packed read: one bit per consecutive vector
   always_comb begin
      vec_byte = '0;
      for (int i = 0; i < BW; i++) begin
         if (xtype == abt_pkg::TYPE_TLK_ERRMAP) begin
            vec_byte[i] = err_mem[addr + AW'(i)];
         end else begin
            vec_byte[i] = wmask_mem[addr + AW'(i)];
         end
      end
   end

   // memory writes carry no reset
   always_ff @(posedge CLK_SYS) begin
      if (wr_pop & (xtype == abt_pkg::TYPE_LSN_EXP)) begin
         exp_mem[addr][chan_base +: BW] <= f_out_data[BW-1:0]; // see R3
      end
      if (wr_pop & (xtype == abt_pkg::TYPE_LSN_WMASK)) begin
         for (int i = 0; i < BW; i++) begin
            wmask_mem[addr + AW'(i)] <= f_out_data[i];         // see R10
         end
      end
      if (ERR_WE) begin
         err_mem[ERR_ADDR] <= ERR_BIT;
      end
   end

   // settings; a refused pair or type keeps the old one
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         first_conn <= 3'h0;
         last_conn <= 3'h1;
         start_addr <= '0;
         xtype <= abt_pkg::TYPE_NONE;
      end else begin
         if (sel_ok) begin
            first_conn <= SEL_FIRST;           // see R2
            last_conn <= SEL_LAST;
         end
         if (ADDR_STB) begin
            start_addr <= ADDR_VAL;            // see R1
         end
         if (TYPE_STB & type_ok) begin
            xtype <= TYPE_VAL;                 // see R5
         end
      end
   end

   // running address; reload waits one cycle so new settings are in place
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         hold <= 1'b1;
         addr <= '0;
         lane <= '0;
      end else begin
         hold <= restart;
         if (hold) begin
            addr <= start_eff;                 // see R1
            lane <= '0;
         end else if (step & word_done) begin
            addr <= addr + (vec ? VEC_STEP : AW'(1)); // see R18
            lane <= '0;
         end else if (step) begin
            lane <= lane + LW'(1);
         end
      end
   end
   // end of memory restarts at the start address, which wraps the data
   // back to the bottom when the start is zero (see R22)

   // bus handshake, acceptor when listening and source when talking
   always_comb begin
      next_st = st;
      case (st)
         abt_pkg::LK_IDLE: begin
            if (lsn_on) begin
               next_st = abt_pkg::LK_ACC_WAIT;
            end else if (tlk_on & f_out_valid & ~hold) begin
               next_st = abt_pkg::LK_SRC_RFD;
            end
         end
         abt_pkg::LK_ACC_WAIT: begin
            if (!lsn_on) begin
               next_st = abt_pkg::LK_IDLE;
            end else if (acc_take) begin
               next_st = abt_pkg::LK_ACC_DONE;
            end
         end
         abt_pkg::LK_ACC_DONE: begin
            if (!dav) begin
               next_st = lsn_on ? abt_pkg::LK_ACC_WAIT : abt_pkg::LK_IDLE;
            end
         end
         abt_pkg::LK_SRC_RFD: begin
            if (!tlk_on) begin
               next_st = abt_pkg::LK_IDLE;
            end else if (!nrfd & ndac) begin
               next_st = abt_pkg::LK_SRC_DAV;
            end
         end
         abt_pkg::LK_SRC_DAV: begin
            if (!ndac | !tlk_on) begin
               next_st = abt_pkg::LK_SRC_END;
            end
         end
         abt_pkg::LK_SRC_END: begin
            if (ndac | !tlk_on) begin
               next_st = abt_pkg::LK_IDLE;
            end
         end
         default: begin
            next_st = abt_pkg::LK_IDLE;
         end
      endcase
   end

   // line drivers; data settles a cycle before DAV is asserted
   wire src_data = (next_st == abt_pkg::LK_SRC_RFD) | (next_st == abt_pkg::LK_SRC_DAV);
   wire next_nrfd = ((next_st == abt_pkg::LK_ACC_WAIT) & ~f_in_ready) |
                    (next_st == abt_pkg::LK_ACC_DONE);
   wire next_ndac = (next_st == abt_pkg::LK_ACC_WAIT);
   wire next_dav = (next_st == abt_pkg::LK_SRC_DAV);
   wire next_eoi = src_data & f_out_data[BW];       // see R6
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         st <= abt_pkg::LK_IDLE;
         DIO_N_OE <= 1'b0;
         DIO_N_OUT <= 8'hFF;
         {NRFD_N_OE, NDAC_N_OE, DAV_N_OE, EOI_N_OE} <= 4'h0;
         {NRFD_N_OUT, NDAC_N_OUT, DAV_N_OUT, EOI_N_OUT} <= 4'hF;
      end else begin
         st <= next_st;
         DIO_N_OE <= src_data;
         DIO_N_OUT <= ~f_out_data[BW-1:0];
         {NRFD_N_OE, NDAC_N_OE, DAV_N_OE, EOI_N_OE} <=
            {next_nrfd, next_ndac, next_dav, next_eoi};
         {NRFD_N_OUT, NDAC_N_OUT, DAV_N_OUT, EOI_N_OUT} <=
            ~{next_nrfd, next_ndac, next_dav, next_eoi};
      end
   end

   // two status levels; a new event beats the poll that clears the level
   wire [abt_pkg::STAT_W-1:0] ev = {wr_eoi, SEL_STB & sel_bad}; // see R20
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         stat0 <= '0;
         stat1 <= '0;
      end else if (SPOLL_DONE) begin
         stat0 <= stat1 | ev;                  // see R8
         stat1 <= '0;
      end else if (stat0 == '0) begin
         stat0 <= ev;
      end else begin
         stat1 <= stat1 | ev;
      end
   end

   // segment count and observation registers
   assign log_map = map_logical(addr, vec, STOP_ANALYSIS, GLITCH_ON); // see R13
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         segs <= abt_pkg::SEG_ONE;
         SRQ <= 1'b0;
         STATUS <= 8'h00;
         LOG_ADDR <= '0;
         LOG_NEG <= 1'b0;
         GLITCH_HALF <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         if (CLR_SEG_STB) begin
            segs <= abt_pkg::SEG_ONE;          // see R17
         end else if (ADD_SEG_STB & (segs != abt_pkg::SEG_MAX)) begin
            segs <= segs + abt_pkg::SEG_ONE;
         end
         SRQ <= (stat0 != '0);
         STATUS <= 8'h00;
         STATUS[abt_pkg::ST_RQS] <= (stat0 != '0);
         STATUS[abt_pkg::STAT_W-1:0] <= stat0;
         LOG_ADDR <= log_map[AW-1:0];          // see R14 R15 R16
         LOG_NEG <= log_map[AW];
         GLITCH_HALF <= log_map[AW+1];
         BUSY <= (st != abt_pkg::LK_IDLE) | f_out_valid;
      end
   end
   assign XFER_ADDR = addr;
   assign SEG_COUNT = segs;
endmodule
`default_nettype wire

//--- abt_pkg.sv
/*
   abt_pkg: constants, transfer type codes and link states shared by the
   binary block transfer port and its byte fifo.
   assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package abt_pkg;
   // transfer type codes as the command decoder delivers them
   localparam logic [2:0] TYPE_NONE = 3'h0;
   localparam logic [2:0] TYPE_LSN_EXP = 3'h1;
   localparam logic [2:0] TYPE_TLK_EXP = 3'h2;
   localparam logic [2:0] TYPE_LSN_WMASK = 3'h3;
   localparam logic [2:0] TYPE_TLK_WMASK = 3'h4;
   localparam logic [2:0] TYPE_TLK_ERRMAP = 3'h5;
   // memory geometry
   localparam int ADDR_W = 14;
   localparam int CHAN_W = 32;
   localparam int BYTE_W = 8;
   localparam int CONN_W = 3;
   localparam int LANE_W = 2;
   localparam int CBASE_W = 5;
   localparam int VEC_SH = 3;
   // byte fifo, one extra bit carries the end flag
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 9;
   // segment counter
   localparam int SEG_W = 4;
   localparam logic [3:0] SEG_ONE = 4'h1;
   localparam logic [3:0] SEG_MAX = 4'hF;
   // status byte layout
   localparam int STAT_W = 2;
   localparam int ST_CONN_ERR = 0;
   localparam int ST_XFER_END = 1;
   localparam int ST_RQS = 6;
   // positions in the synchronised pin vector
   localparam int SY_DAV = 8;
   localparam int SY_NRFD = 9;
   localparam int SY_NDAC = 10;
   localparam int SY_EOI = 11;
   localparam int SY_W = 12;
   // bus handshake states
   typedef enum logic [2:0] {
      LK_IDLE = 3'b000,
      LK_ACC_WAIT = 3'b001,
      LK_ACC_DONE = 3'b010,
      LK_SRC_RFD = 3'b011,
      LK_SRC_DAV = 3'b100,
      LK_SRC_END = 3'b101
   } abt_link_t;
endpackage
`default_nettype wire

//--- abt_fifo.sv
/*
   abt_fifo: small synchronous fifo with valid and ready on both sides.
   assumes: DEPTH is a power of two; one clock; flush has priority.
*/
`default_nettype none
module abt_fifo #(
   parameter int WIDTH = abt_pkg::FIFO_W,
   parameter int DEPTH = abt_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;

   // honest flags straight from the occupancy count
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = (count != FULL);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   // pointers wrap on their own since depth is a power of two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + PW'(push);
         rd_ptr <= rd_ptr + PW'(pop);
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // storage carries no reset, contents are only read behind count
   always_ff @(posedge clk) begin
      if (push & ~flush) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

//--- abt_port_assertions.sv
/*
   abt_port_assertions: concurrent checks on the ports of abt_port.
   assumes: bound into every abt_port; one clock, RST_N asynchronous low.
*/
`default_nettype none
module abt_port_assertions #(
   parameter int AW = abt_pkg::ADDR_W
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // commands and levels
   input wire logic SEL_STB,
   input wire logic [2:0] SEL_FIRST,
   input wire logic [2:0] SEL_LAST,
   input wire logic ADDR_STB,
   input wire logic [AW-1:0] ADDR_VAL,
   input wire logic TYPE_STB,
   input wire logic [2:0] TYPE_VAL,
   input wire logic CLR_SEG_STB,
   input wire logic ADD_SEG_STB,
   input wire logic EXTENDED,
   input wire logic [2:0] TOP_CONN,
   input wire logic LISTEN_BIN,
   input wire logic TALK_BIN,
   // bus lines
   input wire logic DAV_N_IN,
   input wire logic DIO_N_OE,
   input wire logic DAV_N_OE,
   input wire logic NRFD_N_OE,
   input wire logic NDAC_N_OE,
   // status
   input wire logic SRQ,
   input wire logic [7:0] STATUS,
   input wire logic [AW-1:0] XFER_ADDR,
   input wire logic [3:0] SEG_COUNT
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // aligned start so the check holds for every transfer type
   a_addr_reload: assert property (ADDR_STB && ADDR_VAL[2:0] == 3'h0 ##1 !ADDR_STB
      |-> ##1 XFER_ADDR == $past(ADDR_VAL, 2)) else $error("start address not reloaded");
   a_vec_align: assert property (TYPE_STB && EXTENDED && TYPE_VAL >= 3'h3
      && TYPE_VAL <= 3'h5 |-> ##2 XFER_ADDR[2:0] == 3'h0) else $error("vector start unaligned");
   a_pair_srq: assert property (SEL_STB && SEL_FIRST > SEL_LAST |-> ##[2:3] SRQ)
      else $error("reversed pair raised no request");
   a_pair_top: assert property (SEL_STB && SEL_LAST > TOP_CONN
      |-> ##[1:2] STATUS[abt_pkg::ST_CONN_ERR]) else $error("pair above top not flagged");
   a_seg_clear: assert property (CLR_SEG_STB && !ADD_SEG_STB |=> SEG_COUNT == 4'h1)
      else $error("segment clear did not leave one");
   a_seg_add: assert property (ADD_SEG_STB && !CLR_SEG_STB && SEG_COUNT != 4'hF
      |=> SEG_COUNT == $past(SEG_COUNT) + 4'h1) else $error("segment add missed");
   a_listen_take: assert property ($fell(NDAC_N_OE) && LISTEN_BIN && $past(LISTEN_BIN)
      |-> $past(DAV_N_IN, 3) == 1'b0) else $error("byte accepted without data valid");
   a_dav_data: assert property (DAV_N_OE |-> DIO_N_OE)
      else $error("data valid without data driven");
   a_talk_drop: assert property ($fell(TALK_BIN) |-> ##[1:3] !DAV_N_OE)
      else $error("data valid kept after talk ended");
   a_idle_quiet: assert property ((!LISTEN_BIN && !TALK_BIN) [*4]
      |-> !DIO_N_OE && !DAV_N_OE && !NRFD_N_OE && !NDAC_N_OE) else $error("bus driven idle");
   // main scenarios reached
   c_srq: cover property (SRQ);
   c_take: cover property ($fell(NDAC_N_OE));
   c_talk: cover property ($rose(DAV_N_OE));
endmodule
bind abt_port abt_port_assertions #(.AW(AW)) chk_u (.*);
`default_nettype wire

//--- abt_ctrl_model.sv
/*
   abt_ctrl_model: bus controller on the far side, as source and acceptor.
   assumes: bench resolves the open drain wires; lines high when released.
*/
`default_nettype none
module abt_ctrl_model (
   // clock
   input wire logic clk,
   // resolved bus lines
   input wire logic [7:0] dio_n,
   input wire logic dav_n,
   input wire logic nrfd_n,
   input wire logic ndac_n,
   input wire logic eoi_n,
   // own drives, high when released
   output logic [7:0] c_dio_n,
   output logic c_dav_n,
   output logic c_nrfd_n,
   output logic c_ndac_n,
   output logic c_eoi_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int fails = 0;
   wire logic [2:0] ln = {ndac_n, nrfd_n, dav_n};
   initial {c_dio_n, c_dav_n, c_nrfd_n, c_ndac_n, c_eoi_n} = 12'hFFF;
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   // bounded wait on one handshake line; a stuck bus counts as a fault
   task automatic await(input int i, input logic lvl);
      int n;
      n = 0;
      while (ln[i] !== lvl && n < 100) begin
         tick;
         n++;
      end
      if (n == 100) fails++;
   endtask
   // source: wait for a listener holding ndac, else a lone bus looks accepted
   task automatic send(input logic [7:0] d, input logic last);
      await(2, 1'b0);
      await(1, 1'b1);
      c_dio_n = ~d;
      c_eoi_n = ~last;
      tick;
      c_dav_n = 1'b0;
      await(2, 1'b1);
      c_dav_n = 1'b1;
      c_dio_n = 8'hFF;
      c_eoi_n = 1'b1;
   endtask
   // acceptor: every byte is data, line ends included
   task automatic recv(output logic [7:0] d, output logic e);
      c_ndac_n = 1'b0;
      c_nrfd_n = 1'b1;
      await(0, 1'b0);
      d = ~dio_n;
      e = !eoi_n;
      c_nrfd_n = 1'b0;
      c_ndac_n = 1'b1;
      await(0, 1'b1);
   endtask
endmodule
`default_nettype wire

//--- tb_abt_port.sv
/*
   tb_abt_port: bench for the binary block transfer port with a controller
   model across the three-wire handshake.
   assumes: abt_pkg, abt_fifo, abt_port and abt_ctrl_model compiled first.
*/
`default_nettype none
module tb_abt_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_SYS, RST_N, SEL_STB, ADDR_STB, TYPE_STB, CLR_SEG_STB, ADD_SEG_STB, SPOLL_DONE;
   logic EXTENDED, STOP_ANALYSIS, GLITCH_ON, LISTEN_BIN, TALK_BIN, ADDR_CHG, re;
   logic [2:0] SEL_FIRST, SEL_LAST, TYPE_VAL, TOP_CONN;
   logic [13:0] ADDR_VAL, XFER_ADDR, LOG_ADDR;
   logic [7:0] DIO_N_OUT, STATUS, c_dio, w_dio, rd;
   logic DIO_N_OE, DAV_N_OUT, DAV_N_OE, NRFD_N_OUT, NRFD_N_OE, NDAC_N_OUT, NDAC_N_OE;
   logic EOI_N_OUT, EOI_N_OE, SRQ, LOG_NEG, GLITCH_HALF, BUSY;
   logic c_dav, c_nrfd, c_ndac, c_eoi, w_dav, w_nrfd, w_ndac, w_eoi;
   logic [3:0] SEG_COUNT;
   int bad_count = 0;
   int num_checks = 0;
   // open drain: a released line floats high on its pull-up
   assign w_dio = (DIO_N_OE ? DIO_N_OUT : 8'hFF) & c_dio;
   assign w_dav = (DAV_N_OE ? DAV_N_OUT : 1'b1) & c_dav;
   assign w_nrfd = (NRFD_N_OE ? NRFD_N_OUT : 1'b1) & c_nrfd;
   assign w_ndac = (NDAC_N_OE ? NDAC_N_OUT : 1'b1) & c_ndac;
   assign w_eoi = (EOI_N_OE ? EOI_N_OUT : 1'b1) & c_eoi;
   abt_port #(.AW(14), .FD(8)) dut_u (.*, .DIO_N_IN(w_dio), .DAV_N_IN(w_dav),
      .NRFD_N_IN(w_nrfd), .NDAC_N_IN(w_ndac), .EOI_N_IN(w_eoi), .ERR_WE(1'b0),
      .ERR_ADDR(14'h0000), .ERR_BIT(1'b0));
   abt_ctrl_model ctl_u (.clk(CLK_SYS), .dio_n(w_dio), .dav_n(w_dav), .nrfd_n(w_nrfd),
      .ndac_n(w_ndac), .eoi_n(w_eoi), .c_dio_n(c_dio), .c_dav_n(c_dav), .c_nrfd_n(c_nrfd),
      .c_ndac_n(c_ndac), .c_eoi_n(c_eoi));
   initial begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   task automatic tick;
      @(posedge CLK_SYS);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // k: 0 start, 1 type, 2 pair as {first,last}, 3 add, 4 clear, 5 poll
   task automatic cmd(input int k, input logic [13:0] v);
      ADDR_VAL = v;
      TYPE_VAL = v[2:0];
      SEL_FIRST = v[5:3];
      SEL_LAST = v[2:0];
      {ADDR_STB, TYPE_STB, SEL_STB, ADD_SEG_STB, CLR_SEG_STB, SPOLL_DONE} = 6'h20 >> k;
      tick;
      {ADDR_STB, TYPE_STB, SEL_STB, ADD_SEG_STB, CLR_SEG_STB, SPOLL_DONE} = 6'h00;
      repeat (2) tick;
   endtask
   // a hang ends the run as a failure; the tests need well under 2000 cycles
   initial begin
      #400000;
      bad_count++;
      complete_run;
   end
   initial begin
      {ADDR_STB, TYPE_STB, SEL_STB, ADD_SEG_STB, CLR_SEG_STB, SPOLL_DONE} = 6'h00;
      {EXTENDED, GLITCH_ON, LISTEN_BIN, TALK_BIN, ADDR_CHG} = 5'h00;
      {ADDR_VAL, SEL_FIRST, SEL_LAST, TYPE_VAL} = 23'h000000;
      STOP_ANALYSIS = 1'b1;
      TOP_CONN = 3'h5;
      RST_N = 1'b0;
      repeat (4) @(posedge CLK_SYS);
      #1;
      RST_N = 1'b1;
      repeat (2) tick;
      chk({SRQ, STATUS}, 9'h000);
      chk(SEG_COUNT, 4'h1);
      chk(XFER_ADDR, 14'h0000);
      cmd(3, 14'h0000);
      cmd(3, 14'h0000);
      chk(SEG_COUNT, 4'h3);
      cmd(4, 14'h0000);
      chk(SEG_COUNT, 4'h1);
      // reversed pair, then a pair past the top connector; two polls clear each
      for (int i = 0; i < 2; i++) begin
         cmd(2, i ? 14'h0007 : 14'h001A);
         repeat (2) tick;
         chk({SRQ, STATUS[0]}, 2'h3);
         cmd(5, 14'h0000);
         cmd(5, 14'h0000);
         repeat (2) tick;
         chk({SRQ, STATUS}, 9'h000);
      end
      cmd(2, 14'h0001);
      cmd(0, 14'h0008);
      chk(XFER_ADDR, 14'h0008);
      cmd(1, 14'h0001);
      chk(XFER_ADDR, 14'h0008);
      chk({LOG_NEG, LOG_ADDR}, 15'h0008);
      // write two bytes, a line-end code first and the last one flagged
      LISTEN_BIN = 1'b1;
      ctl_u.send(8'h0D, 1'b0);
      repeat (8) tick;
      chk(XFER_ADDR, 14'h0009);
      ctl_u.send(8'hA5, 1'b1);
      repeat (8) tick;
      chk(STATUS[1], 1'b1);
      chk(XFER_ADDR, 14'h0008);
      LISTEN_BIN = 1'b0;
      // read back after the controller stalls long enough to fill the prefetch
      cmd(1, 14'h0002);
      TALK_BIN = 1'b1;
      repeat (30) tick;
      ctl_u.recv(rd, re);
      chk({re, rd}, 9'h00D);
      ctl_u.recv(rd, re);
      chk({re, rd}, 9'h0A5);
      TALK_BIN = 1'b0;
      // vector types from an unaligned start
      EXTENDED = 1'b1;
      cmd(0, 14'h000C);
      for (int t = 3; t < 6; t++) begin
         cmd(1, 14'(t));
         chk(XFER_ADDR, 14'h0008);
      end
      repeat (2) tick;
      chk({LOG_NEG, LOG_ADDR}, 15'h7FF7);
      GLITCH_ON = 1'b1;
      repeat (2) tick;
      chk({GLITCH_HALF, LOG_NEG, LOG_ADDR}, 16'h5FF7);
      chk(BUSY, 1'b0);
      chk(ctl_u.fails, 0);
      complete_run;
   end
endmodule
`default_nettype wire
